//--- hdl/dapx_ahb_slv.sv
// bus slave front end turning bus transfers into register requests
`timescale 1ns/100ps
module dapx_ahb_slv (
    input  wire logic        sys_clk,   // system clock
    input  wire logic        nrst,      // async reset
    input  wire logic        hsel,      // slave select
    input  wire logic [31:0] haddr,     // address
    input  wire logic [1:0]  htrans,    // transfer type
    input  wire logic        hwrite,    // write flag
    input  wire logic [31:0] hwdata,    // write data
    input  wire logic        hready,    // bus ready
    output logic             hreadyout, // slave ready
    output logic [31:0]      hrdata,    // read data
    output logic             hresp,     // response
    dapx_reg_if.slv          rif        // register side
);
    import dapx_pkg::*;
    typedef struct packed {
        logic       pend;
        logic       write;
        logic [7:0] addr;
    } dapx_slv_t;
    dapx_slv_t s, next_s;

    always_comb begin
        next_s = s;
        if (hready) begin
            next_s.pend  = hsel && (htrans == HTRANS_NSEQ);
            next_s.write = hwrite;
            next_s.addr  = haddr[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rif.req   = s.pend;
    assign rif.write = s.write;
    assign rif.addr  = s.addr;
    assign rif.wdata = hwdata;
    assign hreadyout = !s.pend || rif.ready;
    assign hrdata    = rif.rdata;
    assign hresp     = 1'b0;
endmodule

//--- hdl/dapx_axi_port.sv
// debug memory access port: register core and wide memory bus master
// Operation
// - barrier register read/write; only bits 2:1 and 0 defined, 31:3 read zero
// - type 01 memory barrier, 11 sync barrier; bit0 reads 0 while busy
// - with tagging, 64-bit accesses exist; 4-bit tags per 16-byte granule
// - tagged reads use transfer tag op, tagged writes update tag op
// - 64-bit read issued as 128-bit transaction, unused bytes dropped
// - 64-bit write issued as 128-bit transaction, strobes only on 64 bits
// - without realm support protection bit 1 picks secure or non-secure
// - with realm support extension bit and protection bit pick the space
// - access to a space not permitted performs no memory access
// - control bits 30:28 drive protection, 27:24 drive cache attributes
// - non-secure bit high drives line high; secure needs permit else none
// - protection field resets to 0110000
// - control bit 23 shows the secure debug authentication input
// - bits 22:21 show realm and root access status, else zero
// - bit 15 enables tag exchange through the tag register
// - bits 14:13 drive domain; reset to system
// - bit 12 supplies space extension with realm support, else zero
// - byte, half and word sizes supported, larger optional
// - encryption contexts recommended when memory system supports them; this port has no encryption context output
`timescale 1ns/100ps
module dapx_axi_port #(
    parameter bit HAS_TAG   = 1'b1, // tagging present
    parameter bit HAS_REALM = 1'b1, // realm extension present
    parameter bit HAS_DWORD = 1'b1  // 64-bit size present
) (
    input  wire logic        sys_clk,       // 40 MHz clock
    input  wire logic        nrst,          // async reset
    input  wire logic        hsel,          // slave select
    input  wire logic [31:0] haddr,         // address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write flag
    input  wire logic [2:0]  hsize,         // size, word only
    input  wire logic [31:0] hwdata,        // write data
    input  wire logic        hready,        // bus ready
    output logic             hreadyout,     // slave ready
    output logic [31:0]      hrdata,        // read data
    output logic             hresp,         // response
    input  wire logic        secureInvasiveDebugAuth, // auth pin
    input  wire logic [1:0]  realmRootAccessStatus,   // realm/root pins
    output logic             arValid,       // read address valid
    input  wire logic        arReady,       // read address ready
    output logic [31:0]      arAddr,        // read address
    output logic [2:0]       arSize,        // read size
    output logic [2:0]       arProt,        // read protection
    output logic [3:0]       arCache,       // read cache
    output logic [1:0]       arDomain,      // read domain
    output logic             arSpaceExt,    // read space extension
    output logic [1:0]       arTagop,       // read tag op
    input  wire logic        rValid,        // read data valid
    output logic             rReady,        // read data ready
    input  wire logic [127:0] rData,        // read data
    input  wire logic [3:0]  rTag,          // read tag
    output logic             awValid,       // write address valid
    input  wire logic        awReady,       // write address ready
    output logic [31:0]      awAddr,        // write address
    output logic [2:0]       awSize,        // write size
    output logic [2:0]       awProt,        // write protection
    output logic [3:0]       awCache,       // write cache
    output logic [1:0]       awDomain,      // write domain
    output logic             awSpaceExt,    // write space extension
    output logic [1:0]       awTagop,       // write tag op
    output logic             wValid,        // write data valid
    input  wire logic        wReady,        // write data ready
    output logic [127:0]     wData,         // write data
    output logic [15:0]      wStrb,         // write strobes
    output logic [3:0]       wTag,          // write tag
    input  wire logic        bValid,        // write response valid
    output logic             bReady,        // write response ready
    output logic             barValid,      // barrier request
    output logic [1:0]       barType,       // barrier kind
    input  wire logic        barReady,      // barrier accepted
    input  wire logic        barResp        // barrier complete pulse
);
    import dapx_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_ACK} dapx_fsm_t;
    typedef struct packed {
        dapx_fsm_t   fsm;
        logic [6:0]  prot;
        logic [1:0]  domain;
        logic        tagEn;
        logic        spaceExt;
        logic [2:0]  size;
        logic [31:0] addr;
        logic [31:0] dataLo;
        logic [31:0] dataHi;
        logic [3:0]  tag;
        logic [1:0]  barKind;
        logic        barBusy;
        logic        barSent;
        logic        fault;
        logic [1:0]  authSync;
        logic [1:0]  realmS1;
        logic [1:0]  realmS2;
        logic [31:0] rdata;
        logic        arV;
        logic        awV;
        logic        wV;
    } dapx_top_t;

    dapx_top_t s, next_s;
    dapx_reg_if rif ();

    logic [31:0] ctrlWord;
    logic [31:0] regRead;
    logic        sizeOk;
    logic        spaceOk;
    logic        accessOk;
    logic [31:0] busAddr;
    logic [31:0] rdLo;
    logic [31:0] rdHi;
    logic [2:0]  axSize;

    // ==========================================
    // bus front end and lane placement
    dapx_ahb_slv u_slv (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .rif       (rif.slv)
    );

    dapx_lane u_lane (
        .addr   (s.addr[3:0]),
        .size   (s.size),
        .lo     (s.dataLo),
        .hi     (s.dataHi),
        .rdBus  (rData),
        .strb   (wStrb),
        .axSize (axSize),
        .wBus   (wData),
        .rdLo   (rdLo),
        .rdHi   (rdHi)
    );

    // ==========================================
    // register read view
    always_comb begin
        ctrlWord = '0;
        ctrlWord[CTL_PROT_LSB +: 7] = s.prot;
        ctrlWord[CTL_AUTH_BIT] = s.authSync[1];
        ctrlWord[CTL_REALM_LSB +: 2] = HAS_REALM ? s.realmS2 : 2'h0;
        ctrlWord[CTL_TAGEN_BIT] = s.tagEn;
        ctrlWord[CTL_DOM_LSB +: 2] = s.domain;
        ctrlWord[CTL_SPX_BIT] = s.spaceExt;
        ctrlWord[2:0] = s.size;
    end

    always_comb begin
        case (rif.addr)
            OFS_CTRL:    regRead = ctrlWord;
            OFS_ADDR:    regRead = s.addr;
            OFS_DATA:    regRead = s.dataLo;
            OFS_DATAHI:  regRead = s.dataHi;
            OFS_TAG:     regRead = {28'h0, s.tag};
            OFS_BARRIER: regRead = {29'h0, s.barKind, !s.barBusy};
            OFS_FAULT:   regRead = {31'h0, s.fault};
            default:     regRead = '0;
        endcase
    end

    // ==========================================
    // access permission
    assign sizeOk = (s.size <= SZ_WORD) || (HAS_DWORD && s.size == SZ_DWORD);
    always_comb begin
        if (HAS_REALM && s.spaceExt) begin
            spaceOk = s.prot[5] ? s.realmS2[0] : (s.realmS2 == 2'h3);
        end else begin
            spaceOk = s.prot[5] || s.authSync[1];
        end
    end
    assign accessOk = sizeOk && spaceOk;

    // ==========================================
    // next state
    always_comb begin
        next_s = s;
        next_s.authSync = {s.authSync[0], secureInvasiveDebugAuth};
        next_s.realmS1  = realmRootAccessStatus;
        next_s.realmS2  = s.realmS1;
        // barrier runs beside register traffic
        if (s.barBusy && !s.barSent && barReady) begin
            next_s.barSent = 1'b1;
        end
        if (s.barBusy && s.barSent && barResp) begin
            next_s.barBusy = 1'b0;
            next_s.barSent = 1'b0;
        end
        case (s.fsm)
            ST_IDLE: begin
                if (rif.req) begin
                    next_s.fsm = ST_ACK;
                    next_s.rdata = regRead;
                    if (rif.write) begin
                        case (rif.addr)
                            OFS_CTRL: begin
                                next_s.prot = rif.wdata[CTL_PROT_LSB +: 7];
                                next_s.tagEn = HAS_TAG && rif.wdata[CTL_TAGEN_BIT];
                                next_s.domain = rif.wdata[CTL_DOM_LSB +: 2];
                                next_s.spaceExt = HAS_REALM && rif.wdata[CTL_SPX_BIT];
                                next_s.size = rif.wdata[2:0];
                            end
                            OFS_ADDR:   next_s.addr = rif.wdata;
                            OFS_DATAHI: next_s.dataHi = rif.wdata;
                            OFS_TAG:    next_s.tag = rif.wdata[3:0];
                            OFS_FAULT: begin
                                if (rif.wdata[0]) begin
                                    next_s.fault = 1'b0;
                                end
                            end
                            OFS_BARRIER: begin
                                next_s.barKind = rif.wdata[2:1];
                                if (!s.barBusy && rif.wdata[0]
                                    && (rif.wdata[2:1] == BAR_MEM
                                        || rif.wdata[2:1] == BAR_SYNC)) begin
                                    next_s.barBusy = 1'b1;
                                end
                            end
                            default: ;
                        endcase
                    end
                    if (rif.addr == OFS_DATA) begin
                        if (!accessOk) begin
                            next_s.fault = 1'b1;
                            next_s.rdata = '0;
                        end else if (rif.write) begin
                            next_s.dataLo = rif.wdata;
                            next_s.awV = 1'b1;
                            next_s.wV = 1'b1;
                            next_s.fsm = ST_WR;
                        end else begin
                            next_s.arV = 1'b1;
                            next_s.fsm = ST_RD;
                        end
                    end
                end
            end
            ST_RD: begin
                if (s.arV && arReady) begin
                    next_s.arV = 1'b0;
                end
                if (!s.arV && rValid) begin
                    next_s.dataLo = rdLo;
                    next_s.rdata = rdLo;
                    if (s.size == SZ_DWORD) begin
                        next_s.dataHi = rdHi;
                    end
                    if (s.tagEn) begin
                        next_s.tag = rTag;
                    end
                    next_s.fsm = ST_ACK;
                end
            end
            ST_WR: begin
                if (s.awV && awReady) begin
                    next_s.awV = 1'b0;
                end
                if (s.wV && wReady) begin
                    next_s.wV = 1'b0;
                end
                if (!s.awV && !s.wV && bValid) begin
                    next_s.fsm = ST_ACK;
                end
            end
            ST_ACK: next_s.fsm = ST_IDLE;
            default: next_s.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s        <= '0;
            s.prot   <= PROT_RST;
            s.domain <= DOM_RST;
            s.size   <= SIZE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // outputs; no encryption context port
    assign rif.ready = (s.fsm == ST_ACK);
    assign rif.rdata = s.rdata;
    assign busAddr = (s.size == SZ_DWORD) ? {s.addr[31:4], 4'h0} : s.addr;
    assign arValid = s.arV;
    assign arAddr = busAddr;
    assign arSize = axSize;
    assign arProt = s.prot[6:4];
    assign arCache = s.prot[3:0];
    assign arDomain = s.domain;
    assign arSpaceExt = s.spaceExt;
    assign arTagop = s.tagEn ? TAGOP_XFER : TAGOP_NONE;
    assign rReady = (s.fsm == ST_RD) && !s.arV;
    assign awValid = s.awV;
    assign awAddr = busAddr;
    assign awSize = axSize;
    assign awProt = s.prot[6:4];
    assign awCache = s.prot[3:0];
    assign awDomain = s.domain;
    assign awSpaceExt = s.spaceExt;
    assign awTagop = s.tagEn ? TAGOP_UPD : TAGOP_NONE;
    assign wValid = s.wV;
    assign wTag = s.tag;
    assign bReady = (s.fsm == ST_WR) && !s.awV && !s.wV;
    assign barValid = s.barBusy && !s.barSent;
    assign barType = s.barKind;

    // ==========================================
    // checks
    property p_barRes;
        @(posedge sys_clk) disable iff (!nrst)
        (s.fsm == ST_IDLE && rif.req && !rif.write && rif.addr == OFS_BARRIER)
        |=> (rif.rdata[31:3] == 29'h0 && rif.rdata[0] == !$past(s.barBusy));
    endproperty
    a_barRes: assert property (p_barRes) else $error("barrier read wrong");

    property p_barStart;
        @(posedge sys_clk) disable iff (!nrst)
        (s.fsm == ST_IDLE && rif.req && rif.write && rif.addr == OFS_BARRIER
         && !s.barBusy && rif.wdata[0] && rif.wdata[2:1] == BAR_SYNC)
        |=> barValid && barType == BAR_SYNC;
    endproperty
    a_barStart: assert property (p_barStart) else $error("barrier not issued");

    property p_barDone;
        @(posedge sys_clk) disable iff (!nrst)
        (s.barBusy && !s.barSent) |=> s.barBusy;
    endproperty
    a_barDone: assert property (p_barDone) else $error("barrier cleared early");

    property p_rdTag;
        @(posedge sys_clk) disable iff (!nrst)
        (arValid && s.tagEn) |-> arTagop == TAGOP_XFER;
    endproperty
    a_rdTag: assert property (p_rdTag) else $error("read tag op wrong");

    property p_wrTag;
        @(posedge sys_clk) disable iff (!nrst)
        (awValid && s.tagEn) |-> awTagop == TAGOP_UPD;
    endproperty
    a_wrTag: assert property (p_wrTag) else $error("write tag op wrong");

    property p_rdWide;
        @(posedge sys_clk) disable iff (!nrst)
        (arValid && s.size == SZ_DWORD) |-> (arSize == AX_SZ_QW && arAddr[3:0] == 4'h0);
    endproperty
    a_rdWide: assert property (p_rdWide) else $error("64-bit read not widened");

    property p_wrStrb;
        @(posedge sys_clk) disable iff (!nrst)
        (wValid && s.size == SZ_DWORD)
        |-> ($countones(wStrb) == 8 && awSize == AX_SZ_QW);
    endproperty
    a_wrStrb: assert property (p_wrStrb) else $error("64-bit strobes wrong");

    property p_secure;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(arValid) |-> (arProt[1] || $past(s.authSync[1]) || (HAS_REALM && arSpaceExt));
    endproperty
    a_secure: assert property (p_secure) else $error("secure read without permit");

    property p_deny;
        @(posedge sys_clk) disable iff (!nrst)
        (s.fsm == ST_IDLE && rif.req && rif.addr == OFS_DATA && !accessOk)
        |=> (s.fsm == ST_ACK && !arValid && !awValid) ##1 s.fault;
    endproperty
    a_deny: assert property (p_deny) else $error("denied access went out");

    property p_auth;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(secureInvasiveDebugAuth) |-> ##2 ctrlWord[CTL_AUTH_BIT];
    endproperty
    a_auth: assert property (p_auth) else $error("auth bit not reflected");
endmodule

//--- hdl/dapx_lane.sv
// byte lane placement and strobes on the wide data bus
`timescale 1ns/100ps
module dapx_lane (
    input  wire logic [3:0]   addr,   // low address bits
    input  wire logic [2:0]   size,   // access size
    input  wire logic [31:0]  lo,     // low write word
    input  wire logic [31:0]  hi,     // high write word
    input  wire logic [127:0] rdBus,  // read bus
    output logic [15:0]       strb,   // write strobes
    output logic [2:0]        axSize, // bus size
    output logic [127:0]      wBus,   // placed write data
    output logic [31:0]       rdLo,   // selected low word
    output logic [31:0]       rdHi    // selected high word
);
    import dapx_pkg::*;
    logic [4:0] nBytes;
    logic [4:0] base;
    logic       dw;

    assign dw     = (size == SZ_DWORD);
    assign nBytes = 5'h01 << size;
    assign base   = {1'b0, addr & ~(nBytes[3:0] - 4'h1)};
    assign axSize = dw ? AX_SZ_QW : size;
    assign wBus   = dw ? {2{hi, lo}} : {4{lo}};
    assign rdLo   = rdBus[{addr[3:2], 5'h00} +: 32];
    assign rdHi   = rdBus[{addr[3], 6'h20} +: 32];

    // only the bytes of the intended access are strobed
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_strb
            assign strb[i] = (5'(i) >= base) && (5'(i) < base + nBytes);
        end
    endgenerate
endmodule

//--- inc/dapx_pkg.sv
// constants shared by the debug memory access port
package dapx_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ADDR    = 8'h04;
    localparam logic [7:0] OFS_DATA    = 8'h0c;
    localparam logic [7:0] OFS_DATAHI  = 8'h10;
    localparam logic [7:0] OFS_TAG     = 8'h14;
    localparam logic [7:0] OFS_BARRIER = 8'h18;
    localparam logic [7:0] OFS_FAULT   = 8'h1c;
    // ==========================================
    // control word field positions
    localparam int CTL_PROT_LSB  = 24;
    localparam int CTL_AUTH_BIT  = 23;
    localparam int CTL_REALM_LSB = 21;
    localparam int CTL_TAGEN_BIT = 15;
    localparam int CTL_DOM_LSB   = 13;
    localparam int CTL_SPX_BIT   = 12;
    // ==========================================
    // reset values
    localparam logic [6:0] PROT_RST = 7'h30;
    localparam logic [1:0] DOM_RST  = 2'h3;
    localparam logic [2:0] SIZE_RST = 3'h2;
    // ==========================================
    // access sizes
    localparam logic [2:0] SZ_BYTE  = 3'h0;
    localparam logic [2:0] SZ_HALF  = 3'h1;
    localparam logic [2:0] SZ_WORD  = 3'h2;
    localparam logic [2:0] SZ_DWORD = 3'h3;
    localparam logic [2:0] AX_SZ_QW = 3'h4;
    // ==========================================
    // barrier, tag and bus transfer codes
    localparam logic [1:0] BAR_MEM     = 2'h1;
    localparam logic [1:0] BAR_SYNC    = 2'h3;
    localparam logic [1:0] TAGOP_NONE  = 2'h0;
    localparam logic [1:0] TAGOP_XFER  = 2'h1;
    localparam logic [1:0] TAGOP_UPD   = 2'h2;
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
endpackage

//--- inc/dapx_reg_if.sv
// register request carrier between bus slave and register core
`timescale 1ns/100ps
interface dapx_reg_if;
    logic        req;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ready;
    modport slv (output req, write, addr, wdata, input rdata, ready);
    modport core (input req, write, addr, wdata, output rdata, ready);
endinterface

//--- verification/dapx_mem_model.sv
// behavioural wide memory bus and barrier responder
`timescale 1ns/100ps
module dapx_mem_model (
    input  wire logic         sys_clk,  // clock
    input  wire logic         nrst,     // reset
    input  wire logic         arValid,  // rd req
    output logic              arReady,  // rd accept
    output logic              rValid,   // rd valid
    input  wire logic         rReady,   // rd taken
    output logic [127:0]      rData,    // rd data
    input  wire logic         awValid,  // wr req
    output logic              awReady,  // wr accept
    input  wire logic         wValid,   // data valid
    output logic              wReady,   // data accept
    input  wire logic [127:0] wData,    // wr data
    input  wire logic [15:0]  wStrb,    // strobes
    output logic              bValid,   // wr done
    input  wire logic         bReady,   // done taken
    input  wire logic         barValid, // barrier req
    output logic              barReady, // barrier accept
    output logic              barResp   // barrier done
);
    logic [127:0] memLine;
    logic [3:0]   barCnt;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {arReady, rValid, awReady, wReady, bValid, barReady, barResp} <= '0;
            {rData, memLine, barCnt} <= {128'h1, 128'h0, 4'h0};
        end else begin
            arReady  <= arValid && !arReady;
            awReady  <= awValid && !awReady;
            wReady   <= wValid && !wReady;
            barReady <= barValid && !barReady;
            barCnt   <= (barValid && barReady) ? 4'h6 : barCnt - (barCnt != 4'h0);
            barResp  <= (barCnt == 4'h1); // slow completion
            if (arValid && arReady) begin
                {rValid, rData} <= {1'b1, memLine};
            end else if (rValid && rReady) begin
                {rValid, rData} <= {1'b0, ~rData}; // no stale data
            end
            if (wValid && wReady) begin
                bValid <= 1'b1;
                for (int i = 0; i < 16; i++) begin
                    if (wStrb[i]) memLine[8*i+:8] <= wData[8*i+:8];
                end
            end else if (bValid && bReady) begin
                bValid <= 1'b0;
            end
        end
    end
endmodule

//--- verification/test_debug_axi5_memory_access_port.sv
// self-checking bench for the debug memory access port
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("BAD %0t mismatch %h %h", $time, a, b); end end
module test_debug_axi5_memory_access_port;
    import dapx_pkg::*;
    logic         sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0, hready, hreadyout;
    logic         hresp, arValid, arReady, rValid, rReady, awValid, awReady, wValid, wReady;
    logic         bValid, bReady, barValid, barReady, barResp, arSpaceExt, awSpaceExt;
    logic         secureInvasiveDebugAuth = 1'b1;
    logic [1:0]   htrans = 2'h0, realmRootAccessStatus = 2'h0, barType;
    logic [1:0]   arDomain, awDomain, arTagop, awTagop;
    logic [2:0]   hsize = SZ_WORD, arSize, awSize, arProt, awProt;
    logic [3:0]   arCache, awCache, rTag = 4'h9, wTag;
    logic [15:0]  wStrb, stS;
    logic [14:0]  arS, awS;
    logic [31:0]  haddr = '0, hwdata = '0, hrdata, arAddr, awAddr, q;
    logic [127:0] rData, wData;
    int           err_total = 0, tests_run = 0, nBar = 0, nAcc = 0;
    assign hready = hreadyout;
    dapx_axi_port u_dut (.*);
    dapx_mem_model u_mem (.*);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (arValid && arReady) arS <= {arProt, arCache, arDomain, arSpaceExt, arTagop, arSize};
        if (awValid && awReady) awS <= {awProt, awCache, awDomain, awSpaceExt, awTagop, awSize};
        if (wValid && wReady) stS <= wStrb;
        if ((arValid && arReady) || (awValid && awReady)) nAcc++;
        if (barValid && barReady) nBar++;
    end
    function automatic logic [31:0] ctl(logic [2:0] p, logic [3:0] c, logic t, logic n, logic [2:0] s);
        return {1'b0, p, c, 8'h0, t, 2'b01, n, 9'h0, s};
    endfunction
    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        {htrans, hwrite, haddr} <= {HTRANS_NSEQ, w, 24'h0, a};
        n = 0;
        do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 200);
        {htrans, hwdata} <= {2'h0, d};
        do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 200);
        r = hrdata;
        if (n >= 200) begin err_total++; finish_test(); end
    endtask
    task automatic wait3(input logic a, input logic [1:0] s);
        {secureInvasiveDebugAuth, realmRootAccessStatus} <= {a, s};
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic t_reset();
        bus(1'b0, OFS_CTRL, 32'h0, q);
        `CHK({q[30:24], q[14:13], q[23]}, {PROT_RST, DOM_RST, 1'b1})
        `CHK({arProt, arDomain}, 5'b01111)
        wait3(1'b0, 2'h3);
        bus(1'b0, OFS_CTRL, 32'h0, q);
        `CHK(q[23:21], 3'b011)
    endtask
    task automatic t_barrier();
        logic [31:0] d;
        for (int i = 0; i < 2; i++) begin
            d = i ? 32'hffff_ffff : 32'hffff_fffb;
            bus(1'b1, OFS_BARRIER, d, q);
            bus(1'b0, OFS_BARRIER, 32'h0, q);
            `CHK(q, d & 32'h6)
            repeat (10) @(posedge sys_clk);
            bus(1'b0, OFS_BARRIER, 32'h0, q);
            `CHK({q, barType}, {d & 32'h7, d[2:1]})
        end
        bus(1'b1, OFS_BARRIER, 32'h5, q);
        repeat (10) @(posedge sys_clk);
        `CHK(nBar, 2)
    endtask
    task automatic t_word();
        bus(1'b1, OFS_CTRL, ctl(3'h2, 4'ha, 1'b0, 1'b0, SZ_WORD), q);
        bus(1'b1, OFS_ADDR, 32'h14, q);
        bus(1'b1, OFS_DATA, 32'h1234_5678, q);
        bus(1'b0, OFS_DATA, 32'h0, q);
        `CHK({q, stS}, {32'h1234_5678, 16'h00f0})
        `CHK(awS, {3'h2, 4'ha, 2'b01, 1'b0, TAGOP_NONE, SZ_WORD})
        `CHK(arS, awS)
        bus(1'b1, OFS_CTRL, ctl(3'h2, 4'ha, 1'b0, 1'b0, SZ_BYTE), q);
        bus(1'b1, OFS_ADDR, 32'h17, q);
        bus(1'b1, OFS_DATA, 32'habab_abab, q);
        `CHK(stS, 16'h0080)
        `CHK({awAddr, hresp}, {32'h17, 1'b0})
    endtask
    task automatic t_dword();
        bus(1'b1, OFS_CTRL, ctl(3'h2, 4'ha, 1'b1, 1'b0, SZ_DWORD), q);
        bus(1'b1, OFS_ADDR, 32'h8, q);
        bus(1'b1, OFS_DATAHI, 32'haaaa_bbbb, q);
        bus(1'b1, OFS_DATA, 32'hcccc_dddd, q);
        `CHK({stS, awS[4:0]}, {16'hff00, TAGOP_UPD, AX_SZ_QW})
        bus(1'b1, OFS_ADDR, 32'h0, q);
        bus(1'b0, OFS_DATA, 32'h0, q);
        `CHK({q, arS[4:0]}, {32'h0, TAGOP_XFER, AX_SZ_QW})
        bus(1'b0, OFS_DATAHI, 32'h0, q);
        `CHK(q, 32'hab34_5678)
        bus(1'b0, OFS_CTRL, 32'h0, q);
        `CHK(q[15], 1'b1)
        bus(1'b0, OFS_TAG, 32'h0, q);
        `CHK({q, wTag}, {32'h9, 4'h9})
    endtask
    task automatic t_deny();
        int n;
        n = nAcc;
        bus(1'b1, OFS_CTRL, ctl(3'h0, 4'h0, 1'b0, 1'b0, SZ_WORD), q);
        bus(1'b0, OFS_DATA, 32'h0, q);
        `CHK(q, 32'h0)
        wait3(1'b0, 2'h0);
        bus(1'b1, OFS_CTRL, ctl(3'h2, 4'h0, 1'b0, 1'b1, SZ_WORD), q);
        bus(1'b1, OFS_DATA, 32'h0, q);
        `CHK(nAcc, n)
        wait3(1'b1, 2'h1);
        bus(1'b0, OFS_DATA, 32'h0, q);
        `CHK({nAcc, arS[14:5]}, {n + 1, 3'h2, 4'h0, 2'b01, 1'b1})
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_barrier();
        t_word();
        t_dword();
        t_deny();
        finish_test();
    end
endmodule
